/* dv/ibc_instrument_model.sv */
// instrument on the far side: acceptor, source and service request
`timescale 1ns/1ps
`include "ibc_defs.svh"

module ibc_instrument_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic listen,
  input wire logic slow,
  input wire logic srqOn,
  input wire logic talkGo,
  input wire logic [7:0] talkByte,
  input wire logic [7:0] dioW,
  input wire logic [7:0] ctlW,
  output logic [7:0] dioOe,
  output logic [7:0] ctlOe,
  output logic [7:0] gotByte
);
  logic davLow;
  logic ndacOe_reg;
  logic davOe_reg;
  logic [7:0] dioOe_reg;
  logic [1:0] talkSt_reg;
  logic [2:0] waitCnt_reg;
  logic [2:0] waitLimit;

  assign davLow = !ctlW[`IBC_LN_DAV];
  assign waitLimit = slow ? 3'h6 : 3'h0;
  // released lines float to the pull-up, never hold a stale level
  assign ctlOe = {4'h0, srqOn, listen & davLow, davOe_reg, ndacOe_reg};
  assign dioOe = dioOe_reg;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ndacOe_reg <= 1'b0;
      davOe_reg <= 1'b0;
      dioOe_reg <= 8'h00;
      talkSt_reg <= 2'h0;
      waitCnt_reg <= 3'h0;
      gotByte <= 8'h00;
    end else begin
      if (!listen || !davLow) begin
        ndacOe_reg <= listen;
        waitCnt_reg <= 3'h0;
      end else if (waitCnt_reg != waitLimit) begin
        waitCnt_reg <= waitCnt_reg + 3'h1;
      end else if (ndacOe_reg) begin
        ndacOe_reg <= 1'b0;
        gotByte <= ~dioW;
      end
      case (talkSt_reg)
        2'h0: if (talkGo) begin
          dioOe_reg <= talkByte;
          talkSt_reg <= 2'h1;
        end
        2'h1: if (ctlW[`IBC_LN_NRFD] && !ctlW[`IBC_LN_NDAC]) begin
          davOe_reg <= 1'b1;
          talkSt_reg <= 2'h2;
        end
        2'h2: if (ctlW[`IBC_LN_NDAC]) begin
          davOe_reg <= 1'b0;
          dioOe_reg <= 8'h00;
          talkSt_reg <= 2'h0;
        end
        default: talkSt_reg <= 2'h0;
      endcase
    end
  end
endmodule : ibc_instrument_model

/* dv/test_instrument_bus_controller.sv */
// self-checking bench of the instrument bus controller
`timescale 1ns/1ps
`include "ibc_defs.svh"

module test_instrument_bus_controller;
  localparam logic [15:0] ST = `IBC_BASE_ADDR;
  localparam logic [15:0] DT = `IBC_BASE_ADDR + `IBC_DATA_OFFSET;
  localparam logic [8:0] EV = `IBC_ERR_VECTOR;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic busInit = 1'b0, busRead = 1'b0, busWrite = 1'b0, busByte = 1'b0;
  logic err1Inhibit = 1'b0, listen = 1'b0, slow = 1'b0;
  logic srqOn = 1'b0, talkGo = 1'b0;
  logic [15:0] busAddr = 16'h0000, busWdata = 16'h0000;
  logic [7:0] extOe = 8'h00, talkByte = 8'h00;
  logic [15:0] busRdata, rv;
  logic busReply, irqReq, rr;
  logic [8:0] irqVector;
  logic [7:0] dioOe, dioOut, ctlOe, ctlOut, mDioOe, mCtlOe, gotByte;
  // every party pulls low; the pull-up wins when nobody drives
  wire logic [7:0] dioW = ~(dioOe | mDioOe);
  wire logic [7:0] ctlW = ~(ctlOe | mCtlOe | extOe);
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;

  always #50 clk = ~clk;

  // short clear pulse keeps the run brief
  ibc_controller #(.IFC_CYCLES(20)) uut (.clk(clk), .rstn(rstn),
    .busInit(busInit), .busAddr(busAddr), .busRead(busRead),
    .busWrite(busWrite), .busByte(busByte), .busWdata(busWdata),
    .busRdata(busRdata), .busReply(busReply), .irqReq(irqReq),
    .irqVector(irqVector), .err1Inhibit(err1Inhibit), .dioIn(dioW),
    .dioOut(dioOut), .dioOe(dioOe), .ctlIn(ctlW), .ctlOut(ctlOut),
    .ctlOe(ctlOe));

  ibc_instrument_model peer (.clk(clk), .rstn(rstn), .listen(listen),
    .slow(slow), .srqOn(srqOn), .talkGo(talkGo), .talkByte(talkByte),
    .dioW(dioW), .ctlW(ctlW), .dioOe(mDioOe), .ctlOe(mCtlOe),
    .gotByte(gotByte));

  // ******************************
  // host access and comparison
  // ******************************
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    compares++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk

  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    busAddr <= a;
    busRead <= 1'b1;
    @(posedge clk);
    busRead <= 1'b0;
    @(negedge clk);
    rv = busRdata;
    rr = busReply;
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic b);
    @(posedge clk);
    busAddr <= a;
    busWdata <= d;
    busByte <= b;
    busWrite <= 1'b1;
    @(posedge clk);
    busWrite <= 1'b0;
  endtask : wr

  task automatic rdm(input logic [15:0] a, input logic [15:0] m,
                     input logic [15:0] e, input string nm);
    rd(a);
    chk(nm, e, rv & m);
  endtask : rdm

  task automatic waitbit(input int b);
    int i;
    rd(ST);
    for (i = 0; i < 200 && rv[b] !== 1'b1; i++) rd(ST);
    chk("status bit wait", 16'h0001, {15'h0000, rv[b]});
  endtask : waitbit

  task automatic talk(input logic [7:0] b);
    @(posedge clk);
    talkByte <= b;
    talkGo <= 1'b1;
    @(posedge clk);
    talkGo <= 1'b0;
    waitbit(`IBC_ST_LNR);
  endtask : talk

  task automatic finish_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ******************************
  // scenarios
  // ******************************
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    rdm(ST, 16'hffff, 16'h0000, "status reset");
    rdm(DT, 16'hffff, 16'h0500, "monitor idle");
    chk("mapped reply", 16'h0001, {15'h0000, rr});
    rd(ST + 16'h0004);
    chk("unmapped reply", 16'h0000, {15'h0000, rr});
    wr(ST, 16'h1836, 1'b0);
    rdm(ST, 16'hffff, 16'h0236, "status control");
    chk("remote eop drive", 16'h0090, {8'h00, ctlOe & 8'h90});
    chk("idle outputs", 16'hff00, {dioOut, ctlOut & 8'h90});
    rdm(DT, 16'hf000, 16'h9000, "monitor lines");
    wr(ST, 16'h0080, 1'b0);
    rdm(ST, 16'h0200, 16'h0000, "talker ready off");
    chk("idle accept nrfd", 16'h0004, {8'h00, ctlOe & 8'h04});
    srqOn <= 1'b1;
    wr(ST, 16'h0040, 1'b0);
    rdm(ST, 16'h8000, 16'h8000, "srq status");
    chk("srq irq", {7'h01, EV + 9'h004}, {6'h00, irqReq, irqVector});
    wr(ST, 16'h0000, 1'b0);
    rd(ST);
    chk("irq gated", 16'h0000, {15'h0000, irqReq});
    srqOn <= 1'b0;
    extOe <= 8'h10;
    rdm(ST, 16'h2000, 16'h2000, "line conflict");
    err1Inhibit <= 1'b1;
    rdm(ST, 16'h2000, 16'h0000, "conflict inhibited");
    extOe <= 8'h00;
    err1Inhibit <= 1'b0;
    rdm(ST, 16'h2000, 16'h0000, "conflict gone");
    wr(ST, 16'h0008, 1'b0);
    repeat (2) @(negedge clk);
    chk("ifc drive", 16'h0020, {8'h00, ctlOe & 8'h20});
    waitbit(`IBC_ST_TCS);
    rdm(ST, 16'h0008, 16'h0000, "bus clear ends");
    waitbit(`IBC_ST_CMD);
    chk("atn on nrfd off", 16'h0040, {8'h00, ctlOe & 8'h44});
    // slow and prompt acceptor on consecutive command bytes
    listen <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      slow <= i[0];
      wr(DT, i[0] ? 16'h005a : 16'h00a5, 1'b1);
      waitbit(`IBC_ST_CMD);
      chk("cmd byte", i[0] ? 16'h005a : 16'h00a5, {8'h00, gotByte});
    end
    listen <= 1'b0;
    wr(ST, 16'h0060, 1'b0);
    waitbit(`IBC_ST_TKR);
    wr(DT, 16'h0011, 1'b1);
    rdm(ST, 16'h4000, 16'h4000, "no acceptor");
    chk("error vector", {7'h00, EV}, {7'h00, irqVector});
    chk("lines untouched", 16'h0000, {8'h00, dioOe});
    wr(ST, 16'h0000, 1'b0);
    rdm(ST, 16'h4000, 16'h0000, "no acceptor clear");
    wr(ST, 16'h0050, 1'b0);
    talk(8'hc3);
    chk("listener vector", {7'h00, EV + 9'h00c}, {7'h00, irqVector});
    rdm(DT, 16'h00ff, 16'h00c3, "read byte");
    rdm(ST, 16'h0100, 16'h0000, "read accepts");
    wr(ST, 16'h00d0, 1'b0);
    talk(8'h3c);
    rdm(DT, 16'h00ff, 16'h003c, "accept mode byte");
    rdm(ST, 16'h0100, 16'h0100, "read keeps ready");
    wr(DT, 16'h0000, 1'b1);
    rdm(ST, 16'h0100, 16'h0000, "zero write accepts");
    wr(ST, 16'h0076, 1'b0);
    extOe <= 8'h20;
    rdm(ST, 16'h02b6, 16'h0000, "ifc received");
    extOe <= 8'h00;
    @(posedge clk);
    busInit <= 1'b1;
    @(posedge clk);
    busInit <= 1'b0;
    rdm(ST, 16'h00ff, 16'h0000, "init clears");
    finish_test();
  end
endmodule : test_instrument_bus_controller

/* pkg/ibc_defs.svh */
// offsets, field positions, reset values and timing counts
`ifndef IBC_DEFS_SVH
`define IBC_DEFS_SVH

// register map: data register sits one word above status
`define IBC_BASE_ADDR 16'he068
`define IBC_DATA_OFFSET 16'h0002
`define IBC_ERR_VECTOR 9'h110
`define IBC_VECTOR_STEP 9'h004

// status register fields
`define IBC_ST_SRQ 15
`define IBC_ST_ERR2 14
`define IBC_ST_ERR1 13
`define IBC_ST_CMD 10
`define IBC_ST_TKR 9
`define IBC_ST_LNR 8
`define IBC_ST_ACC 7
`define IBC_ST_IE 6
`define IBC_ST_TON 5
`define IBC_ST_LON 4
`define IBC_ST_IBC 3
`define IBC_ST_REM 2
`define IBC_ST_EOP 1
`define IBC_ST_TCS 0
`define IBC_CTL_RESET 8'h00

// control line index, same order as the monitor high byte
`define IBC_LN_EOI 7
`define IBC_LN_ATN 6
`define IBC_LN_IFC 5
`define IBC_LN_REN 4
`define IBC_LN_SRQ 3
`define IBC_LN_NRFD 2
`define IBC_LN_DAV 1
`define IBC_LN_NDAC 0
// lines that read one when low; the two negated ones read one when high
`define IBC_MON_INVERT 8'hfa

// timing
`define IBC_CLK_NS 100
`define IBC_SETTLE_NS 500
`define IBC_SETTLE_CYC ((`IBC_SETTLE_NS + `IBC_CLK_NS - 1) / `IBC_CLK_NS)
`define IBC_IFC_US 125
`define IBC_IFC_CYC ((`IBC_IFC_US * 1000) / `IBC_CLK_NS)

`endif

/* pkg/ibc_pkg.sv */
// state types of the instrument bus controller
package ibc_pkg;

  typedef enum logic [3:0] {
    SH_IDLE = 4'b0001,
    SH_WAIT_RFD = 4'b0010,
    SH_DAV = 4'b0100,
    SH_END = 4'b1000
  } ibc_source_e;

  typedef enum logic [2:0] {
    AH_READY = 3'b001,
    AH_HOLD = 3'b010,
    AH_ACCEPT = 3'b100
  } ibc_accept_e;

  typedef enum logic [4:0] {
    TC_IDLE = 5'b00001,
    TC_HOLD = 5'b00010,
    TC_WAIT_DAV = 5'b00100,
    TC_ATN = 5'b01000,
    TC_DONE = 5'b10000
  } ibc_take_e;

endpackage : ibc_pkg

/* rtl/ibc_controller.sv */
// instrument bus controller: status/control and data/monitor registers
`timescale 1ns/1ps
`include "ibc_defs.svh"

// What this block does
// - data register decodes at status address plus two
// - bit 15 shows service request, interrupts
// - no-acceptor error set on send with accepted
// - line conflict error, blocks attention drive
// - bits 12 and 11 always read zero
// - command-done set and cleared as documented
// - talker-ready set and cleared as documented
// - listener-ready set by data-valid, cleared on accept
// - accept-mode selects read or zero-write accept
// - idle accept-mode asserts not-ready-for-data
// - interrupt enable gates all requests, init clears
// - talker-on and listener-on bits, cleared on clears
// - bus-clear drives interface clear, then takes control
// - remote bit drives remote enable line
// - end-of-poll bit drives end-or-identify line
// - take-control sequence with 500 ns guards
// - data high byte monitors live control lines
// - data low byte reads unlatched data lines
// - low byte write drives lines only when allowed
// - output buffer cleared by init or interface clear
// - four prioritised interrupts, vectors step by four
// - sole controller, ignores parallel poll from others
module ibc_controller import ibc_pkg::*; #(
  parameter logic [15:0] BASE_ADDR = `IBC_BASE_ADDR,
  parameter logic [8:0] ERR_VECTOR = `IBC_ERR_VECTOR,
  parameter int IFC_CYCLES = `IBC_IFC_CYC,
  parameter int SETTLE_CYCLES = `IBC_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic busInit,
  input wire logic [15:0] busAddr,
  input wire logic busRead,
  input wire logic busWrite,
  input wire logic busByte,
  input wire logic [15:0] busWdata,
  output logic [15:0] busRdata,
  output logic busReply,
  output logic irqReq,
  output logic [8:0] irqVector,
  input wire logic err1Inhibit,
  input wire logic [7:0] dioIn,
  output logic [7:0] dioOut,
  output logic [7:0] dioOe,
  input wire logic [7:0] ctlIn,
  output logic [7:0] ctlOut,
  output logic [7:0] ctlOe
);

  // ****************************************************************
  // host bus decode
  // ****************************************************************
  localparam logic [15:0] DATA_ADDR = BASE_ADDR + `IBC_DATA_OFFSET;

  function automatic logic wordHit(input logic [15:0] a,
                                   input logic [15:0] b);
    wordHit = (a[15:1] == b[15:1]);
  endfunction : wordHit

  wire hitStatus = wordHit(busAddr, BASE_ADDR);
  wire hitData = wordHit(busAddr, DATA_ADDR);
  wire lowLane = !busByte || !busAddr[0];
  wire stsWr = busWrite && hitStatus && lowLane;
  wire datWr = busWrite && hitData && lowLane;
  wire datRd = busRead && hitData;

  // ****************************************************************
  // line view (asserted means electrically low)
  // ****************************************************************
  wire [7:0] lineAsserted = ~ctlIn;
  wire davLine = lineAsserted[`IBC_LN_DAV];
  wire atnLine = lineAsserted[`IBC_LN_ATN];
  wire ifcLine = lineAsserted[`IBC_LN_IFC];
  wire renLine = lineAsserted[`IBC_LN_REN];
  wire srqLine = lineAsserted[`IBC_LN_SRQ];
  wire rfdLine = ctlIn[`IBC_LN_NRFD];
  wire dacLine = ctlIn[`IBC_LN_NDAC];

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic err2_reg;
  logic err1_reg;
  logic cmd_reg;
  logic tkr_reg;
  logic lnr_reg;
  logic cmdXfer_reg;
  logic [7:0] outBuf_reg;
  logic atnWant_reg;
  ibc_source_e src_reg;
  ibc_source_e src_next;
  ibc_accept_e acp_reg;
  ibc_accept_e acp_next;
  ibc_take_e tc_reg;
  ibc_take_e tc_next;
  logic ifcBusy;
  logic ifcDone;
  logic tcDone;

  wire acc = ctl_reg[`IBC_ST_ACC];
  wire ie = ctl_reg[`IBC_ST_IE];
  wire talker_on = ctl_reg[`IBC_ST_TON];
  wire listener_on = ctl_reg[`IBC_ST_LON];
  wire remote_drive = ctl_reg[`IBC_ST_REM];
  wire eop = ctl_reg[`IBC_ST_EOP];
  wire take_control = ctl_reg[`IBC_ST_TCS];

  // interface clear from another party; our own pulse is not counted
  wire ifcRx = ifcLine && !ifcBusy &&
               !ctlOe[`IBC_LN_IFC];
  wire softClr = busInit || ifcRx;

  // ****************************************************************
  // control byte
  // ****************************************************************
  wire ibcStart = stsWr && busWdata[`IBC_ST_IBC] && !ctl_reg[`IBC_ST_IBC];

  always_comb begin
    ctl_next = ctl_reg;
    if (stsWr) begin
      ctl_next = busWdata[7:0];
      ctl_next[`IBC_ST_IBC] = ctl_reg[`IBC_ST_IBC] || busWdata[`IBC_ST_IBC];
    end
    if (ifcDone) begin
      ctl_next[`IBC_ST_IBC] = 1'b0;
      ctl_next[`IBC_ST_TCS] = 1'b1;
    end
    if (ifcRx) begin
      ctl_next[`IBC_ST_ACC] = 1'b0;
      ctl_next[`IBC_ST_TON] = 1'b0;
      ctl_next[`IBC_ST_LON] = 1'b0;
      ctl_next[`IBC_ST_REM] = 1'b0;
      ctl_next[`IBC_ST_EOP] = 1'b0;
      ctl_next[`IBC_ST_TCS] = 1'b0;
    end
    if (busInit) begin
      ctl_next = `IBC_CTL_RESET;
    end
  end

  // 125 us interface clear pulse
  ibc_delay_timer #(.WIDTH(16)) u_ifcTimer (
    .clk(clk),
    .rstn(rstn),
    .start(ibcStart),
    .abort(busInit),
    .loadCount(16'(IFC_CYCLES)),
    .busy(ifcBusy),
    .done(ifcDone)
  );

  // ****************************************************************
  // take control synchronously
  // ****************************************************************
  wire tcsRise = ctl_next[`IBC_ST_TCS] && !take_control;
  wire tcTimerStart = (tc_reg == TC_IDLE && take_control) ||
                      (tc_reg == TC_WAIT_DAV && !davLine);

  always_comb begin
    case (tc_reg)
      TC_IDLE: tc_next = take_control ? TC_HOLD : TC_IDLE;
      TC_HOLD: tc_next = tcDone ? TC_WAIT_DAV : TC_HOLD;
      TC_WAIT_DAV: tc_next = davLine ? TC_WAIT_DAV : TC_ATN;
      TC_ATN: tc_next = tcDone ? TC_DONE : TC_ATN;
      TC_DONE: tc_next = TC_DONE;
      default: tc_next = TC_IDLE;
    endcase
    if (!take_control || softClr) begin
      tc_next = TC_IDLE;
    end
  end

  ibc_delay_timer #(.WIDTH(8)) u_tcTimer (
    .clk(clk),
    .rstn(rstn),
    .start(tcTimerStart),
    .abort(!take_control),
    .loadCount(8'(SETTLE_CYCLES)),
    .busy(),
    .done(tcDone)
  );

  wire tcNrfd = (tc_reg == TC_HOLD) || (tc_reg == TC_WAIT_DAV) ||
                (tc_reg == TC_ATN);
  wire atnWant = take_control && ((tc_reg == TC_ATN) || (tc_reg == TC_DONE));
  wire atnDrive = atnWant && !err1_reg;
  wire tcFinish = (tc_reg == TC_ATN) && tcDone;

  // ****************************************************************
  // source handshake
  // ****************************************************************
  wire pathOpen = (talker_on || (take_control && atnLine)) && !davLine;
  wire sendTry = datWr && pathOpen;
  wire noAcceptor = sendTry && dacLine;
  wire sendGo = sendTry && !dacLine && (src_reg == SH_IDLE);
  wire shDone = (src_reg == SH_DAV) && dacLine;

  always_comb begin
    case (src_reg)
      SH_IDLE: src_next = sendGo ? SH_WAIT_RFD : SH_IDLE;
      SH_WAIT_RFD: src_next = rfdLine ? SH_DAV : SH_WAIT_RFD;
      SH_DAV: src_next = dacLine ? SH_END : SH_DAV;
      SH_END: src_next = SH_IDLE;
      default: src_next = SH_IDLE;
    endcase
    if (softClr) begin
      src_next = SH_IDLE;
    end
  end

  // ****************************************************************
  // acceptor handshake
  // ****************************************************************
  wire acceptEv = lnr_reg &&
                  ((datRd && !acc) || (datWr && !pathOpen && acc));
  wire lnrSet = listener_on && davLine && (acp_reg == AH_READY);

  always_comb begin
    case (acp_reg)
      AH_READY: acp_next = lnrSet ? AH_HOLD : AH_READY;
      AH_HOLD: acp_next = acceptEv ? AH_ACCEPT : AH_HOLD;
      AH_ACCEPT: acp_next = davLine ? AH_ACCEPT : AH_READY;
      default: acp_next = AH_READY;
    endcase
    if (!listener_on || softClr) begin
      acp_next = AH_READY;
    end
  end

  // not-ready while holding a byte, during take control, or idle accept
  wire idleAcc = acc && !take_control && !listener_on && !talker_on;
  wire nrfdDrive = tcNrfd || idleAcc ||
                   (listener_on && (acp_reg != AH_READY));
  wire ndacDrive = listener_on && (acp_reg != AH_ACCEPT);

  // ****************************************************************
  // status flags
  // ****************************************************************
  wire tonRise = ctl_next[`IBC_ST_TON] && !talker_on;
  wire tcsFall = !ctl_next[`IBC_ST_TCS] && take_control;
  wire conflict = (atnLine != atnWant_reg) ||
                  (ifcLine != ctlOe[`IBC_LN_IFC]) ||
                  (renLine != ctlOe[`IBC_LN_REN]);
  wire tkrSet = (tonRise && !ctl_next[`IBC_ST_TCS]) ||
                (tcsFall && ctl_next[`IBC_ST_TON]) ||
                (shDone && talker_on && !cmdXfer_reg);
  wire tkrClr = softClr || (sendGo && !take_control) ||
                !ctl_next[`IBC_ST_TON] || ctl_next[`IBC_ST_TCS];
  wire cmdSet = tcFinish || (shDone && cmdXfer_reg);
  wire cmdClr = softClr || (sendGo && take_control) ||
                !ctl_next[`IBC_ST_TCS];

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctl_reg <= `IBC_CTL_RESET;
      err2_reg <= 1'b0;
      err1_reg <= 1'b0;
      cmd_reg <= 1'b0;
      tkr_reg <= 1'b0;
      lnr_reg <= 1'b0;
      cmdXfer_reg <= 1'b0;
      outBuf_reg <= 8'h00;
      atnWant_reg <= 1'b0;
      src_reg <= SH_IDLE;
      acp_reg <= AH_READY;
      tc_reg <= TC_IDLE;
    end else begin
      ctl_reg <= ctl_next;
      // set wins over clear for each latched flag; err1_reg just follows the conflict each cycle unless inhibited
      err2_reg <= noAcceptor || (err2_reg && (talker_on || take_control));
      err1_reg <= conflict && !err1Inhibit;
      cmd_reg <= cmdSet || (cmd_reg && !cmdClr);
      tkr_reg <= tkrSet || (tkr_reg && !tkrClr);
      lnr_reg <= lnrSet || (lnr_reg && !acceptEv && listener_on && !softClr);
      cmdXfer_reg <= sendGo ? take_control : cmdXfer_reg;
      outBuf_reg <= softClr ? 8'h00 :
                    (sendGo ? busWdata[7:0] : outBuf_reg);
      atnWant_reg <= atnWant;
      src_reg <= src_next;
      acp_reg <= acp_next;
      tc_reg <= tc_next;
    end
  end

  // ****************************************************************
  // register read and pin drive
  // ****************************************************************
  wire [15:0] statusWord = {srqLine, err2_reg, err1_reg, 2'b00,
                            cmd_reg, tkr_reg, lnr_reg, ctl_reg};
  wire [15:0] dataWord = {ctlIn ^ `IBC_MON_INVERT, ~dioIn};
  wire [15:0] rdataNext = hitStatus ? statusWord :
                          (hitData ? dataWord : 16'h0000);
  wire hostHit = (busRead || busWrite) && (hitStatus || hitData);

  // data lines only carry our byte while the source owns them; nothing
  // here answers a parallel poll, since we are the only controller
  wire dioDrive = (src_reg == SH_WAIT_RFD) || (src_reg == SH_DAV);
  wire [7:0] dioOeNext = dioDrive ? outBuf_reg : 8'h00;
  wire [7:0] ctlOeNext = {eop, atnDrive, ifcBusy, remote_drive, 1'b0, nrfdDrive,
                          src_reg == SH_DAV, ndacDrive};

  // ****************************************************************
  // interrupt requests
  // ****************************************************************
  wire errReq = err1_reg || err2_reg;
  wire srqReq = srqLine;
  wire ctReq = cmd_reg || tkr_reg;
  wire lnReq = lnr_reg;
  wire [1:0] irqIdx = errReq ? 2'd0 :
                      (srqReq ? 2'd1 : (ctReq ? 2'd2 : 2'd3));
  wire irqNext = ie && (errReq || srqReq || ctReq || lnReq);
  wire [8:0] vecNext = ERR_VECTOR + {5'h00, irqIdx, 2'b00};

  always_ff @(posedge clk) begin
    if (!rstn) begin
      busRdata <= 16'h0000;
      busReply <= 1'b0;
      irqReq <= 1'b0;
      irqVector <= ERR_VECTOR;
      dioOe <= 8'h00;
      dioOut <= 8'hff;
      ctlOe <= 8'h00;
      ctlOut <= 8'hff;
    end else begin
      busRdata <= busRead ? rdataNext : busRdata;
      busReply <= hostHit;
      irqReq <= irqNext;
      irqVector <= vecNext;
      dioOe <= dioOeNext;
      dioOut <= ~dioOeNext;
      ctlOe <= ctlOeNext;
      ctlOut <= ~ctlOeNext;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_data_decode: assert property (@(posedge clk) disable iff (!rstn)
    busRead && hitData |=> busReply && busRdata[7:0] == ~$past(dioIn))
    else $error("data register not answering at base plus two");
  chk_unused_zero: assert property (@(posedge clk) disable iff (!rstn)
    busRead && hitStatus |=> busRdata[12:11] == 2'b00)
    else $error("unused status bits read nonzero");
  chk_err2_hold: assert property (@(posedge clk) disable iff (!rstn)
    noAcceptor |=> err2_reg && src_reg == SH_IDLE)
    else $error("no-acceptor error not raised");
  chk_atn_block: assert property (@(posedge clk) disable iff (!rstn)
    err1_reg |=> !ctlOe[`IBC_LN_ATN])
    else $error("attention driven during line conflict");
  chk_ifc_pulse: assert property (@(posedge clk) disable iff (!rstn)
    ibcStart && !busInit |=> ifcBusy [*8])
    else $error("interface clear pulse ended early");
  chk_ifc_tcs: assert property (@(posedge clk) disable iff (!rstn)
    ifcDone && !busInit && !ifcRx |=> take_control && !ctl_reg[`IBC_ST_IBC])
    else $error("take control not set after bus clear");
  chk_tc_guard: assert property (@(posedge clk) disable iff (!rstn)
    tcsRise && !softClr && !busInit |=> !atnWant [*5])
    else $error("attention asserted before not-ready guard");
  chk_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
    !ie |=> !irqReq)
    else $error("interrupt raised with enable clear");
  chk_irq_order: assert property (@(posedge clk) disable iff (!rstn)
    ie && errReq |=> irqReq && irqVector == ERR_VECTOR)
    else $error("error interrupt not given priority");
  chk_lnr_accept: assert property (@(posedge clk) disable iff (!rstn)
    acceptEv && !lnrSet |=> !lnr_reg ##1 !ctlOe[`IBC_LN_NDAC])
    else $error("accept did not clear ready and release not-accepted");
  chk_idle_nrfd: assert property (@(posedge clk) disable iff (!rstn)
    idleAcc |=> ctlOe[`IBC_LN_NRFD])
    else $error("idle accept mode not holding off the talker");

endmodule : ibc_controller

/* rtl/ibc_delay_timer.sv */
// one-shot down counter giving a busy level and an end pulse
`timescale 1ns/1ps

module ibc_delay_timer #(
  parameter int WIDTH = 12
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic abort,
  input wire logic [WIDTH-1:0] loadCount,
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] count_reg;
  logic [WIDTH-1:0] count_next;
  logic busy_next;
  logic done_next;
  wire lastTick = busy && (count_reg == {{(WIDTH-1){1'b0}}, 1'b1});

  assign count_next = start ? loadCount :
                      (busy ? count_reg - {{(WIDTH-1){1'b0}}, 1'b1}
                            : count_reg);
  assign busy_next = !abort && (start || (busy && !lastTick));
  assign done_next = !abort && !start && lastTick;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      count_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy <= busy_next;
      done <= done_next;
    end
  end

endmodule : ibc_delay_timer
